// File: crc_checksum_engine_test.sv
/*
 * self-checking bench for the checksum engine.
 * assumes crc_pkg, crc_step_if, crc_step, crc_engine and crc_verify_mem compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module crc_checksum_engine_test;
   import crc_pkg::*;
   typedef struct {logic w; crc_word_t s; crc_src_t src; crc_word_t d;} crc_row_t;
   logic      core_clk = 0, rst = 1, ce = 1, seed_load = 0, cfg_wide = 0, go = 0;
   logic      cpu_valid = 0, copy_valid = 0, boot_valid = 0, vv, va, wt, cw, af;
   crc_word_t seed_value = 0, cpu_data = 0, copy_data = 0, boot_data = 0, vd, res, e;
   crc_src_t  ts;
   int        fails = 0, total_checks = 0, cycles = 0, nf = 0;
   crc_row_t  rows [6] = '{'{0, 32'h0, CRC_SRC_CPU, 32'h1}, '{0, 32'hffffffff, CRC_SRC_COPY,
      32'h80000000}, '{0, 32'h1d0f, CRC_SRC_BOOT, 32'hffffffff}, '{1, 32'h0, CRC_SRC_CPU,
      32'h1}, '{1, 32'hffffffff, CRC_SRC_COPY, 32'ha5a5a5a5}, '{1, 32'h1, CRC_SRC_BOOT, 32'h0}};
   crc_engine u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .seed_load(seed_load),
      .seed_value(seed_value), .cfg_wide(cfg_wide), .cpu_valid(cpu_valid), .cpu_data(cpu_data),
      .verify_valid(vv), .verify_data(vd), .verify_allowed(va), .copy_valid(copy_valid),
      .copy_data(copy_data), .boot_valid(boot_valid), .boot_data(boot_data), .crc_result(res),
      .crc_wide(cw), .word_taken(wt), .taken_src(ts), .access_fault(af));
   crc_verify_mem u_mem (.core_clk(core_clk), .rst(rst), .go(go), .verify_valid(vv),
      .verify_data(vd), .verify_allowed(va));
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (af === 1'b1) nf++;
      if (cycles == 2000) begin
         fails++;
         stop_test();
      end
   end
   // ********************
   // helpers
   // ********************
   function automatic crc_word_t fold(crc_word_t c, crc_word_t d, logic w);
      for (int i = 31; i >= 0; i--) begin
         if (w) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY32 : 32'h0);
         else c = {16'h0, c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? {16'h0, CRC_POLY16} : 32'h0);
      end
      return c;
   endfunction
   task automatic chk(string n, crc_word_t seen, crc_word_t exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // drive one word at an edge, release at the sampling edge, then let outputs settle
   task automatic put(crc_src_t s, crc_word_t d, logic sl, logic w, crc_word_t sv);
      @(posedge core_clk);
      seed_load <= sl;
      cfg_wide <= w;
      seed_value <= sv;
      cpu_valid <= (s == CRC_SRC_CPU);
      copy_valid <= (s == CRC_SRC_COPY);
      boot_valid <= (s == CRC_SRC_BOOT);
      {cpu_data, copy_data, boot_data} <= {3{d}};
      @(posedge core_clk);
      {seed_load, cpu_valid, copy_valid, boot_valid} <= 4'h0;
      #1;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ********************
   // sequence
   // ********************
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      #1;
      chk("reset_result", res, CRC_RST_VALUE);
      chk("reset_flags", {26'h0, wt, cw, af, ts}, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         put(rows[i].src, rows[i].d, 1, rows[i].w, rows[i].s);
         e = fold(rows[i].s & (rows[i].w ? CRC_MASK32 : CRC_MASK16), rows[i].d, rows[i].w);
         chk("crc_result", res, e);
         chk("taken_src", {29'h0, ts}, {29'h0, rows[i].src});
         chk("crc_wide", {31'h0, cw}, {31'h0, rows[i].w});
      end
      $display("test table done");
      put(CRC_SRC_CPU, 32'h5a, 0, 0, 32'h0);
      e = fold(e, 32'h5a, 1);
      chk("continue", res, e);
      chk("continue_wide", {31'h0, cw}, 32'h1);
      @(posedge core_clk);
      {boot_valid, copy_valid, cpu_valid} <= 3'h7;
      {boot_data, copy_data, cpu_data} <= {32'h3c, 32'h77, 32'h11};
      @(posedge core_clk);
      {boot_valid, cpu_valid} <= 2'h0;
      ce <= 0;
      #1;
      e = fold(e, 32'h3c, 1);
      chk("priority", {29'h0, ts}, {29'h0, CRC_SRC_BOOT});
      chk("boot_fold", res, e);
      @(posedge core_clk);
      {ce, copy_valid} <= 2'h2;
      #1;
      chk("frozen", res, e);
      chk("frozen_flags", {28'h0, wt, ts}, {28'h0, 1'b1, CRC_SRC_BOOT});
      @(posedge core_clk);
      #1;
      chk("idle", {31'h0, wt}, 32'h0);
      chk("idle_result", res, e);
      put(CRC_SRC_NONE, 32'h0, 1, 0, 32'habcd1234);
      chk("seed16", res, 32'habcd1234 & CRC_MASK16);
      chk("seed16_wide", {31'h0, cw}, 32'h0);
      $display("test awkward done");
      put(CRC_SRC_NONE, 32'h0, 1, 1, 32'h0);
      @(posedge core_clk);
      go <= 1;
      nf = 0;
      @(posedge core_clk);
      go <= 0;
      repeat (4) @(posedge core_clk);
      #1;
      e = 32'h0;
      for (int i = 0; i < 4; i++) if (u_mem.POLICY[i]) e = fold(e, u_mem.mem[i], 1);
      chk("verify_crc", res, e);
      chk("verify_src", {29'h0, ts}, {29'h0, CRC_SRC_VERIFY});
      chk("faults", nf, 1);
      $display("test verify done");
      stop_test();
   end
endmodule // crc_checksum_engine_test
`default_nettype wire

// File: crc_engine.sv
/*
 * checksum engine: 16-bit or 32-bit cyclic checksum over words from the cpu,
 * the memory-verify path, the copy engine and the boot configuration loader.
 * assumes one clock, synchronous inputs, and that the memory access policy
 * check is made outside and reported with each verify word.
 */
`timescale 1ns/1ps
`default_nettype none
module crc_engine (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               ce,
   input  wire logic               seed_load,
   input  wire crc_pkg::crc_word_t seed_value,
   input  wire logic               cfg_wide,
   input  wire logic               cpu_valid,
   input  wire crc_pkg::crc_word_t cpu_data,
   input  wire logic               verify_valid,
   input  wire crc_pkg::crc_word_t verify_data,
   input  wire logic               verify_allowed,
   input  wire logic               copy_valid,
   input  wire crc_pkg::crc_word_t copy_data,
   input  wire logic               boot_valid,
   input  wire crc_pkg::crc_word_t boot_data,
   output var  crc_pkg::crc_word_t crc_result,
   output var  logic               crc_wide,
   output var  logic               word_taken,
   output var  crc_pkg::crc_src_t  taken_src,
   output var  logic               access_fault
);
   import crc_pkg::*;

   crc_word_t  next_crc_result;
   logic       next_crc_wide;
   logic       next_word_taken;
   crc_src_t   next_taken_src;
   logic       next_access_fault;
   crc_word_t  sel_data;
   logic       take;
   crc_word_t  base;
   logic       wide_eff;

   crc_step_if step_bus ();

   crc_step u_step (
      .st (step_bus.calc)
   );

   // ********************
   // source pick and next values
   // ********************
   always_comb begin
      wide_eff          = seed_load ? cfg_wide : crc_wide;
      base              = seed_load ? (seed_value & (cfg_wide ? CRC_MASK32 : CRC_MASK16))
                                    : crc_result;
      sel_data          = '0;
      take              = 1'b0;
      next_taken_src    = CRC_SRC_NONE;
      next_access_fault = 1'b0;
      if (boot_valid) begin
         sel_data       = boot_data;
         take           = 1'b1;
         next_taken_src = CRC_SRC_BOOT;
      end else if (copy_valid) begin
         sel_data       = copy_data;
         take           = 1'b1;
         next_taken_src = CRC_SRC_COPY;
      end else if (verify_valid) begin
         if (verify_allowed) begin
            sel_data       = verify_data;
            take           = 1'b1;
            next_taken_src = CRC_SRC_VERIFY;
         end else begin
            next_access_fault = 1'b1;
         end
      end else if (cpu_valid) begin
         sel_data       = cpu_data;
         take           = 1'b1;
         next_taken_src = CRC_SRC_CPU;
      end
      step_bus.crc_in = base;
      step_bus.data   = sel_data;
      step_bus.wide   = wide_eff;
      next_crc_result = take ? step_bus.crc_out : base;
      next_crc_wide   = wide_eff;
      next_word_taken = take;
   end

   // ********************
   // state registers
   // ********************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         crc_result   <= CRC_RST_VALUE;
         crc_wide     <= 1'b0;
         word_taken   <= 1'b0;
         taken_src    <= CRC_SRC_NONE;
         access_fault <= 1'b0;
      end else if (ce) begin
         crc_result   <= next_crc_result;
         crc_wide     <= next_crc_wide;
         word_taken   <= next_word_taken;
         taken_src    <= next_taken_src;
         access_fault <= next_access_fault;
      end
   end

   // ********************
   // assertions
   // ********************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ********************
   // assertion helpers
   // ********************
   // idle_hold marks a cycle that must leave the checksum alone
   logic no_word;
   logic idle_hold;
   assign no_word   = !boot_valid && !copy_valid && !verify_valid && !cpu_valid;
   assign idle_hold = ce && no_word && !seed_load;

   // ********************
   // named steps
   // ********************
   // one step per source, in priority order
   sequence s_boot_word;
      ce && boot_valid;
   endsequence

   sequence s_copy_word;
      ce && copy_valid && !boot_valid;
   endsequence

   sequence s_verify_word;
      ce && verify_valid && verify_allowed && !copy_valid && !boot_valid;
   endsequence

   sequence s_cpu_word;
      ce && cpu_valid && !verify_valid && !copy_valid && !boot_valid;
   endsequence

   sequence s_denied;
      ce && verify_valid && !verify_allowed && !copy_valid && !boot_valid && !seed_load;
   endsequence

   sequence s_not_denied;
      ce && !(verify_valid && !verify_allowed && !copy_valid && !boot_valid);
   endsequence

   sequence s_seed_wide;
      ce && seed_load && cfg_wide && no_word;
   endsequence

   sequence s_seed_narrow;
      ce && seed_load && !cfg_wide && no_word;
   endsequence

   sequence s_idle;
      idle_hold;
   endsequence

   sequence s_frozen;
      !ce;
   endsequence

   // ********************
   // width and polynomial checks
   // ********************
   AST_P16_VECTOR: assert property (ce && seed_load && !cfg_wide && seed_value == '0
      && cpu_valid && cpu_data == CRC_ONE_WORD && !verify_valid && !copy_valid && !boot_valid
      |=> crc_result == {16'h0000, CRC_POLY16}) else $error("16-bit step result wrong");
   AST_HIGH_ZERO: assert property (!crc_wide |-> (crc_result & ~CRC_MASK16) == '0)
      else $error("16-bit result has high bits set");
   AST_P32_VECTOR: assert property (ce && seed_load && cfg_wide && seed_value == '0
      && cpu_valid && cpu_data == CRC_ONE_WORD && !verify_valid && !copy_valid && !boot_valid
      |=> crc_result == CRC_POLY32) else $error("32-bit step result wrong");
   AST_WIDTH_SEL: assert property (ce && !seed_load ##1 ce && !seed_load |-> $stable(crc_wide))
      else $error("width changed without seed load");
   AST_WIDTH_LATCH: assert property (ce && seed_load |=> crc_wide == $past(cfg_wide))
      else $error("width not taken at seed load");

   // ********************
   // source checks
   // ********************
   AST_DENIED: assert property (s_denied |=> access_fault && !word_taken
      && $stable(crc_result)) else $error("denied verify word altered checksum");
   AST_NO_FAULT: assert property (s_not_denied |=> !access_fault)
      else $error("access fault without a denied verify word");
   AST_VERIFY_WORD: assert property (s_verify_word |=> word_taken
      && taken_src == CRC_SRC_VERIFY && !access_fault) else $error("verify word not folded in");
   AST_COPY_WORD: assert property (s_copy_word |=> word_taken && taken_src == CRC_SRC_COPY)
      else $error("copy word not folded in");
   AST_BOOT_WORD: assert property (s_boot_word |=> word_taken && taken_src == CRC_SRC_BOOT)
      else $error("boot word not folded in");
   AST_CPU_WORD: assert property (s_cpu_word |=> word_taken && taken_src == CRC_SRC_CPU)
      else $error("software word not folded in");

   // ********************
   // seed and hold checks
   // ********************
   // second step looks at the hold only when the cycle before it was idle
   AST_SEED: assert property (s_seed_wide |=> crc_result == $past(seed_value)
      ##1 (!$past(idle_hold) || $stable(crc_result)))
      else $error("seed not loaded or not held");
   AST_SEED16: assert property (s_seed_narrow |=> !crc_wide
      && crc_result == ($past(seed_value) & CRC_MASK16))
      else $error("16-bit seed not masked");
   AST_IDLE: assert property (s_idle |=> !word_taken && !access_fault
      && taken_src == CRC_SRC_NONE && $stable(crc_result))
      else $error("idle cycle changed state");
   // clock enable low freezes every output
   AST_FROZEN: assert property (s_frozen |=> $stable(crc_result) && $stable(crc_wide)
      && $stable(word_taken) && $stable(taken_src) && $stable(access_fault))
      else $error("state moved with clock enable low");
endmodule // crc_engine
`default_nettype wire

// File: crc_pkg.sv
/*
 * constants and types shared by the checksum engine and its bit-step datapath.
 * assumes nothing of its surroundings; compiled first.
 */
`default_nettype none
package crc_pkg;
   // ********************
   // widths and polynomials
   // ********************
   localparam int          CRC_W          = 32;
   localparam int          CRC16_TOP      = 15;
   localparam int          CRC32_TOP      = 31;
   localparam logic [15:0] CRC_POLY16     = 16'h1021;
   localparam logic [31:0] CRC_POLY32     = 32'h04c11db7;
   localparam logic [31:0] CRC_MASK16     = 32'h0000ffff;
   localparam logic [31:0] CRC_MASK32     = 32'hffffffff;
   localparam logic [31:0] CRC_RST_VALUE  = 32'h00000000;
   localparam logic [31:0] CRC_ONE_WORD   = 32'h00000001;

   typedef logic [CRC_W-1:0] crc_word_t;

   // ********************
   // source of the word taken in a cycle
   // ********************
   typedef enum logic [2:0] {
      CRC_SRC_NONE,
      CRC_SRC_CPU,
      CRC_SRC_VERIFY,
      CRC_SRC_COPY,
      CRC_SRC_BOOT
   } crc_src_t;
endpackage : crc_pkg
`default_nettype wire

// File: crc_step.sv
/*
 * one data word folded into a running checksum, msb first, one stage per bit.
 * assumes the 16-bit value sits in the low half with the high half zero.
 */
`timescale 1ns/1ps
`default_nettype none
module crc_step (
   crc_step_if.calc st
);
   import crc_pkg::*;

   crc_word_t chain [0:CRC_W];

   assign chain[0] = st.crc_in;

   // ********************
   // bit chain
   // ********************
   genvar i;
   generate
      for (i = 0; i < CRC_W; i = i + 1) begin : g_bit
         logic      fb16;
         logic      fb32;
         crc_word_t sh16;
         crc_word_t sh32;
         assign fb16 = chain[i][CRC16_TOP] ^ st.data[CRC_W-1-i];
         assign fb32 = chain[i][CRC32_TOP] ^ st.data[CRC_W-1-i];
         assign sh16 = {chain[i][CRC_W-2:0], 1'b0} & CRC_MASK16;
         assign sh32 = {chain[i][CRC_W-2:0], 1'b0};
         assign chain[i+1] = st.wide ? (sh32 ^ (fb32 ? CRC_POLY32 : '0))
                                     : (sh16 ^ (fb16 ? {16'h0000, CRC_POLY16} : '0));
      end
   endgenerate

   assign st.crc_out = chain[CRC_W];
endmodule // crc_step
`default_nettype wire

// File: crc_step_if.sv
/*
 * carrier between the engine and its one-word checksum step.
 * assumes both ends sit in the same clock domain; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface crc_step_if;
   import crc_pkg::*;
   crc_word_t crc_in;
   crc_word_t data;
   logic      wide;
   crc_word_t crc_out;

   modport calc (input crc_in, input data, input wide, output crc_out);
   modport user (output crc_in, output data, output wide, input crc_out);
endinterface : crc_step_if
`default_nettype wire

// File: crc_verify_mem.sv
/*
 * partner: memory-verify path streaming four words with their policy verdicts.
 * assumes one clock shared with the engine; go is a one-cycle start pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module crc_verify_mem (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               go,
   output var  logic               verify_valid,
   output var  crc_pkg::crc_word_t verify_data,
   output var  logic               verify_allowed
);
   import crc_pkg::*;
   localparam logic [3:0] POLICY = 4'hb;
   crc_word_t  mem [4] = '{32'h12345678, 32'h9abcdef0, 32'hdeadbeef, 32'h0f0f0f0f};
   logic [2:0] idx;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) idx <= 3'h4;
      else if (go) idx <= 3'h0;
      else if (idx != 3'h4) idx <= idx + 3'h1;
   end
   // back to back words, one denied; idle bus shows inverted last word
   always_comb begin
      verify_valid   = !idx[2];
      verify_data    = verify_valid ? mem[idx[1:0]] : ~mem[3];
      verify_allowed = verify_valid && POLICY[idx[1:0]];
   end
endmodule // crc_verify_mem
`default_nettype wire
